// >>> spi_rx_dma_wait_bidir_pins_consts.vh
`ifndef SPI_RX_DMA_WAIT_BIDIR_PINS_CONSTS_VH
`define SPI_RX_DMA_WAIT_BIDIR_PINS_CONSTS_VH

// Byte addresses of the word registers
`define ADDR_SERIAL_CONTROL_TWO 4'h0
`define ADDR_UNIT_CONTROL       4'h4
`define ADDR_UNIT_STATUS        4'h8
`define ADDR_RX_DATA            4'hC

// Fields of serial_control_two
`define SCT_BIDIR_OUTPUT_ENABLE 3
`define SCT_RX_DMA_ENABLE       2
`define SCT_WAIT_STOP_BIT       1
`define SCT_PIN_CONTROL_BIT     0
`define SCT_WIDTH               4
`define SCT_RESET               4'h0

// Fields of unit_control
`define UC_SYSTEM_ENABLE        0
`define UC_MASTER_ROLE          1
`define UC_RX_INT_ENABLE        2
`define UC_WIDTH                3
`define UC_RESET                3'h0

// Fields of unit_status
`define US_RX_BUFFER_FULL       0
`define US_RX_DMA_REQUEST       1
`define US_CLOCKS_HALTED        2

// AHB encodings
`define HTRANS_NONSEQ           2'h2
`define HTRANS_SEQ              2'h3
`define HRESP_OKAY              1'h0

// Receive word length
`define RX_WORD_BITS            8
`define RX_COUNT_WIDTH          3

`endif

// >>> spi_rx_dma_wait_bidir_pins.v
`timescale 1ns/1ns
`default_nettype none
`include "spi_rx_dma_wait_bidir_pins_consts.vh"

// Notes on behaviour
// - DMA request when enabled, full, system on
// - DMA enable suppresses receive-full interrupt
// - DMA disabled: no request, interrupt normal
// - Wait stop bit halts clocks in Wait
// - Normal master: in on MISO, out MOSI
// - Normal slave: out on MISO, in MOSI
// - Bidir master: MISO unused, MOSI shared
// - Bidir slave: MOSI unused, MISO shared
// - Bidir output enable drives shared pin
// - Output enable low: shared pin input only
// - Pin control low ignores output enable
// - System disable idles unit, clears flags
module spi_rx_dma_wait_bidir_pins
(
	input  wire        clk,
	input  wire        reset_n,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg         hreadyout,
	output reg         hresp,
	output reg  [31:0] hrdata,
	input  wire        wait_mode,
	input  wire        tx_bit,
	input  wire        sck_in,
	input  wire        mosi_in,
	output reg         mosi_out,
	output reg         mosi_oe_n,
	input  wire        miso_in,
	output reg         miso_out,
	output reg         miso_oe_n,
	output reg         rx_dma_request,
	output reg         rx_interrupt,
	output reg         unit_clock_run
);

	reg  [`SCT_WIDTH-1:0]     serial_control_two;
	reg  [`UC_WIDTH-1:0]      unit_control;
	reg                       rx_buffer_full_flag;
	reg  [`RX_WORD_BITS-1:0]  rx_data;
	reg  [`RX_WORD_BITS-1:0]  rx_shift;
	reg  [`RX_COUNT_WIDTH-1:0] rx_count;
	reg                       wr_pending;
	reg  [3:0]                wr_addr;
	reg                       sck_s1;
	reg                       sck_s2;
	reg                       sck_s3;
	reg                       mosi_s1;
	reg                       mosi_s2;
	reg                       miso_s1;
	reg                       miso_s2;
	reg  [31:0]               next_hrdata;

	wire bidir_output_enable = serial_control_two[`SCT_BIDIR_OUTPUT_ENABLE];
	wire rx_dma_enable       = serial_control_two[`SCT_RX_DMA_ENABLE];
	wire wait_stop_bit       = serial_control_two[`SCT_WAIT_STOP_BIT];
	wire pin_control_bit     = serial_control_two[`SCT_PIN_CONTROL_BIT];
	wire system_enable       = unit_control[`UC_SYSTEM_ENABLE];
	wire master_role         = unit_control[`UC_MASTER_ROLE];
	wire rx_int_enable       = unit_control[`UC_RX_INT_ENABLE];

	wire addr_phase = hsel && hready && (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);
	wire rd_take    = addr_phase && !hwrite;
	wire rd_data    = rd_take && (haddr[3:0] == `ADDR_RX_DATA);

	// Halted clocks freeze the receive path, not the bus slave
	wire clocks_halted = wait_stop_bit && wait_mode;
	wire shift_run     = system_enable && !clocks_halted;
	wire sck_rise      = sck_s2 && !sck_s3;

	// Shared pin follows the role in bidirectional mode
	wire serial_in = pin_control_bit ? (master_role ? mosi_s2 : miso_s2)
		: (master_role ? miso_s2 : mosi_s2);
	wire word_done = shift_run && sck_rise && (rx_count == `RX_WORD_BITS - 1);

	// Bus slave, zero wait states
	always @*
	begin
		next_hrdata = 32'h0000_0000;
		case (haddr[3:0])
			`ADDR_SERIAL_CONTROL_TWO:
				next_hrdata[`SCT_WIDTH-1:0] = serial_control_two;
			`ADDR_UNIT_CONTROL:
				next_hrdata[`UC_WIDTH-1:0] = unit_control;
			`ADDR_UNIT_STATUS:
			begin
				next_hrdata[`US_RX_BUFFER_FULL] = rx_buffer_full_flag;
				next_hrdata[`US_RX_DMA_REQUEST] = rx_dma_request;
				next_hrdata[`US_CLOCKS_HALTED]  = clocks_halted;
			end
			`ADDR_RX_DATA:
				next_hrdata[`RX_WORD_BITS-1:0] = rx_data;
			default:
				next_hrdata = 32'h0000_0000;
		endcase
	end

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			hreadyout  <= 1'b0;
			hresp      <= `HRESP_OKAY;
			hrdata     <= 32'h0000_0000;
			wr_pending <= 1'b0;
			wr_addr    <= 4'h0;
		end
		else
		begin
			hreadyout  <= 1'b1;
			hresp      <= `HRESP_OKAY;
			wr_pending <= addr_phase && hwrite;
			if (addr_phase)
				wr_addr <= haddr[3:0];
			if (rd_take)
				hrdata <= next_hrdata;
		end
	end

	// Register writes land in the data phase
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			serial_control_two <= `SCT_RESET;
			unit_control       <= `UC_RESET;
		end
		else if (wr_pending)
		begin
			if (wr_addr == `ADDR_SERIAL_CONTROL_TWO)
				serial_control_two <= hwdata[`SCT_WIDTH-1:0];
			if (wr_addr == `ADDR_UNIT_CONTROL)
				unit_control <= hwdata[`UC_WIDTH-1:0];
		end
	end

	// Pins and link clock come from outside the clock domain
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sck_s1  <= 1'b0;
			sck_s2  <= 1'b0;
			sck_s3  <= 1'b0;
			mosi_s1 <= 1'b0;
			mosi_s2 <= 1'b0;
			miso_s1 <= 1'b0;
			miso_s2 <= 1'b0;
		end
		else
		begin
			sck_s1  <= sck_in;
			sck_s2  <= sck_s1;
			sck_s3  <= sck_s2;
			mosi_s1 <= mosi_in;
			mosi_s2 <= mosi_s1;
			miso_s1 <= miso_in;
			miso_s2 <= miso_s1;
		end
	end

	// Receive shifter, sampled on link clock rising edges
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_shift <= {`RX_WORD_BITS{1'b0}};
			rx_count <= {`RX_COUNT_WIDTH{1'b0}};
			rx_data  <= {`RX_WORD_BITS{1'b0}};
		end
		else if (!system_enable)
		begin
			rx_shift <= {`RX_WORD_BITS{1'b0}};
			rx_count <= {`RX_COUNT_WIDTH{1'b0}};
		end
		else if (shift_run && sck_rise)
		begin
			rx_shift <= {rx_shift[`RX_WORD_BITS-2:0], serial_in};
			rx_count <= rx_count + 1'b1;
			if (word_done)
				rx_data <= {rx_shift[`RX_WORD_BITS-2:0], serial_in};
		end
	end

	// New word beats a read clear in the same cycle
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rx_buffer_full_flag <= 1'b0;
		else if (!system_enable)
			rx_buffer_full_flag <= 1'b0;
		else if (word_done)
			rx_buffer_full_flag <= 1'b1;
		else if (rd_data)
			rx_buffer_full_flag <= 1'b0;
	end

	// Request and interrupt lag the flag by one cycle
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_dma_request <= 1'b0;
			rx_interrupt   <= 1'b0;
			unit_clock_run <= 1'b1;
		end
		else
		begin
			rx_dma_request <= rx_dma_enable && rx_buffer_full_flag && system_enable;
			rx_interrupt   <= !rx_dma_enable && rx_int_enable && rx_buffer_full_flag
				&& system_enable;
			unit_clock_run <= !clocks_halted;
		end
	end

	// Pin drivers; enables are active low
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mosi_out  <= 1'b0;
			mosi_oe_n <= 1'b1;
			miso_out  <= 1'b0;
			miso_oe_n <= 1'b1;
		end
		else
		begin
			mosi_out <= tx_bit;
			miso_out <= tx_bit;
			if (!system_enable)
			begin
				mosi_oe_n <= 1'b1;
				miso_oe_n <= 1'b1;
			end
			else if (!pin_control_bit)
			begin
				mosi_oe_n <= !master_role;
				miso_oe_n <= master_role;
			end
			else if (master_role)
			begin
				mosi_oe_n <= !bidir_output_enable;
				miso_oe_n <= 1'b1;
			end
			else
			begin
				mosi_oe_n <= 1'b1;
				miso_oe_n <= !bidir_output_enable;
			end
		end
	end

endmodule // spi_rx_dma_wait_bidir_pins

`default_nettype wire

// >>> rx_pins_chk_sva.sv
`timescale 1ns/1ns
`default_nettype none
module rx_pins_chk
(
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        wait_mode,
	input wire logic        tx_bit,
	input wire logic        mosi_out,
	input wire logic        mosi_oe_n,
	input wire logic        miso_out,
	input wire logic        miso_oe_n,
	input wire logic        rx_dma_request,
	input wire logic        rx_interrupt,
	input wire logic        unit_clock_run
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire rd_c = hsel && hready && htrans[1] && !hwrite && haddr[3:0] == 4'hC;
	property p_excl; !(rx_dma_request && rx_interrupt); endproperty
	a_excl: assert property (p_excl) else $error("request and interrupt");
	property p_halt; !unit_clock_run |-> $past(wait_mode); endproperty
	a_halt: assert property (p_halt) else $error("halt without wait");
	property p_run; !wait_mode |=> unit_clock_run; endproperty
	a_run: assert property (p_run) else $error("halted outside wait");
	property p_one; !(!mosi_oe_n && !miso_oe_n); endproperty
	a_one: assert property (p_one) else $error("both pins driven");
	property p_mosi; !mosi_oe_n |-> mosi_out == $past(tx_bit); endproperty
	a_mosi: assert property (p_mosi) else $error("mosi data");
	property p_miso; !miso_oe_n |-> miso_out == $past(tx_bit); endproperty
	a_miso: assert property (p_miso) else $error("miso data");
	property p_rdreq; rd_c |-> ##2 !rx_dma_request; endproperty
	a_rdreq: assert property (p_rdreq) else $error("request after read");
	property p_rdirq; rd_c |-> ##2 !rx_interrupt; endproperty
	a_rdirq: assert property (p_rdirq) else $error("interrupt after read");
endmodule // rx_pins_chk
bind spi_rx_dma_wait_bidir_pins rx_pins_chk chk (.clk, .reset_n, .hsel, .haddr, .htrans,
	.hwrite, .hready, .wait_mode, .tx_bit, .mosi_out, .mosi_oe_n, .miso_out, .miso_oe_n,
	.rx_dma_request, .rx_interrupt, .unit_clock_run);
`default_nettype wire

// >>> spi_far_end.sv
`timescale 1ns/1ns
`default_nettype none
module spi_far_end
(
	output var logic sck,
	output var logic sdo
);
	initial
	begin
		sck = 1'b0;
		sdo = 1'b0;
	end
	// Msb first; clock stands low between frames
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
		begin
			sdo <= b[i];
			#40 sck <= 1'b1;
			#40 sck <= 1'b0;
		end
		// Released line shows the inverse of the last bit
		sdo <= ~sdo;
	endtask
endmodule // spi_far_end
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        wait_mode = 1'b0;
	logic        tx_bit = 1'b0;
	logic        on_mosi = 1'b0;
	logic [31:0] v;
	int          n_mismatch = 0;
	int          checks = 0;
	wire         hreadyout, hresp, mosi_out, mosi_oe_n, miso_out, miso_oe_n, sck, sdo;
	wire         rx_dma_request, rx_interrupt, unit_clock_run;
	wire [31:0]  hrdata;
	// Wrong input pin sees the inverse, so a routing slip corrupts the byte
	wire         mosi_in = mosi_oe_n ? (on_mosi ? sdo : ~sdo) : mosi_out;
	wire         miso_in = miso_oe_n ? (on_mosi ? ~sdo : sdo) : miso_out;
	wire [31:0]  st = {26'h0, hresp, unit_clock_run, mosi_oe_n, miso_oe_n, rx_dma_request,
		rx_interrupt};
	always #5 clk = ~clk;
	always @(posedge clk) tx_bit <= ~tx_bit;
	spi_far_end p (.sck(sck), .sdo(sdo));
	spi_rx_dma_wait_bidir_pins dut (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .wait_mode,
		.tx_bit, .sck_in(sck), .mosi_in, .mosi_out, .mosi_oe_n, .miso_in, .miso_out,
		.miso_oe_n, .rx_dma_request, .rx_interrupt, .unit_clock_run);
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("ERROR %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		{hsel, haddr, htrans, hwrite} <= {1'b1, 28'h0, a, 2'h2, w};
		do @(posedge clk); while (hreadyout !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
		do @(posedge clk); while (hreadyout !== 1'b1);
		v = hrdata;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rx(input logic [7:0] b, input logic m);
		on_mosi <= m;
		p.send(b);
		settle(4);
	endtask
	task automatic t_reset;
		bus(0, 4'h0, 0);
		chk(32'h0, v);
		chk(32'h1C, st);
	endtask
	task automatic t_dma;
		bus(1, 4'h4, 32'h3);
		bus(1, 4'h0, 32'h4);
		rx(8'hA5, 0);
		chk(32'h16, st);
		bus(0, 4'hC, 0);
		chk(32'hA5, v);
		settle(2);
		chk(32'h14, st);
	endtask
	task automatic t_irq;
		bus(1, 4'h4, 32'h7);
		bus(1, 4'h0, 32'h0);
		rx(8'h3C, 0);
		chk(32'h15, st);
		bus(0, 4'hC, 0);
		chk(32'h3C, v);
		rx(8'h5A, 0);
		chk(32'h15, st);
		bus(1, 4'h4, 32'h0);
		settle(2);
		chk(32'h1C, st);
		bus(0, 4'h8, 0);
		chk(32'h0, v);
	endtask
	task automatic t_pins;
		for (int r = 0; r < 2; r++)
			for (int o = 0; o < 2; o++)
			begin
				bus(1, 4'h4, {30'h0, r[0], 1'b1});
				bus(1, 4'h0, {28'h0, o[0], 3'h1});
				settle(2);
				chk({28'h1, r[0] ? ~o[0] : 1'b1, r[0] ? 1'b1 : ~o[0], 2'h0}, st);
				if (!o[0])
				begin
					rx(8'h96, r[0]);
					bus(0, 4'hC, 0);
					chk(32'h96, v);
				end
			end
		bus(1, 4'h4, 32'h1);
		bus(1, 4'h0, 32'h8);
		settle(2);
		chk(32'h18, st);
		rx(8'hC3, 1);
		bus(0, 4'hC, 0);
		chk(32'hC3, v);
	endtask
	task automatic t_wait;
		bus(1, 4'h0, 32'h2);
		@(posedge clk) wait_mode <= 1'b1;
		settle(2);
		chk(32'h08, st);
		// Halted receive path must ignore a whole frame
		rx(8'h55, 1);
		bus(0, 4'h8, 0);
		chk(32'h4, v);
		bus(1, 4'h0, 32'h0);
		settle(2);
		chk(32'h18, st);
		@(posedge clk) wait_mode <= 1'b0;
	endtask
	task automatic results;
		if (n_mismatch == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		#200000;
		n_mismatch++;
		results;
	end
	initial
	begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		t_reset;
		t_dma;
		t_irq;
		t_pins;
		t_wait;
		results;
	end
endmodule // tb
`default_nettype wire
